/* File: rtl/vafp_cfg.svh */
/*
 Timing counts, switch codes, LED rates and parameter defaults for the front panel.
 Assumes a 100 MHz clock; included by the design modules and the verification files, not by the package.
*/
`ifndef VAFP_CFG_SVH
`define VAFP_CFG_SVH
`define VAFP_CLK_MHZ 100
`define VAFP_DEB_US 5000
`define VAFP_DEB_CYC ((`VAFP_DEB_US * `VAFP_CLK_MHZ) - 1)
`define VAFP_TICK_US 1000
`define VAFP_TICK_CYC ((`VAFP_TICK_US * `VAFP_CLK_MHZ) - 1)
`define VAFP_LONG_MS 1000
`define VAFP_SHOW_MS 5000
`define VAFP_IDLE_MIN 10
`define VAFP_IDLE_MS (`VAFP_IDLE_MIN * 60 * 1000)
`define VAFP_FLASH_MS 250
`define VAFP_ROT_MS 250
`define VAFP_VALVE_NONE 7'h00
`define VAFP_VALVE_LAST 7'h04
`define VAFP_VALVE_UNIV 7'h09
`define VAFP_JACK_STEP 12'h064
`define VAFP_PAR_DEF0 16'h0000
`define VAFP_PAR_DEF1 16'h0000
`define VAFP_PAR_DEF2 16'h0064
`define VAFP_PAR_DEF3 16'h0000
`endif

/* File: rtl/vafp_pkg.sv */
/*
 Types shared by the front-panel modules.
 Assumes nothing from vafp_cfg.svh, which it does not include.
*/
package vafp_pkg;
   typedef enum logic [2:0]
   {
      VAFP_RUN = 3'h0,
      VAFP_SEL = 3'h1,
      VAFP_EDIT = 3'h3
   } vafp_state_t;
   typedef enum logic [1:0]
   {
      VAFP_LED_OFF = 2'h0,
      VAFP_LED_GRN = 2'h1,
      VAFP_LED_RED = 2'h2
   } vafp_led_t;
endpackage : vafp_pkg

/* File: rtl/vafp_keys_if.sv */
/*
 Clean key and switch levels passed from the input conditioner to the panel core.
 Assumes one clock domain.
*/
`timescale 1ns/1ns
interface vafp_keys_if;
   logic set_key;
   logic plus_key;
   logic minus_key;
   logic [3:0] sw_tens;
   logic [3:0] sw_units;
   logic tick_ms;
   modport src (output set_key, plus_key, minus_key, sw_tens, sw_units, tick_ms);
   modport dst (input set_key, plus_key, minus_key, sw_tens, sw_units, tick_ms);
endinterface : vafp_keys_if

/* File: rtl/vafp_debounce.sv */
/*
 Synchronises and debounces keys and rotary switches and makes a 1 ms tick.
 Assumes raw inputs arrive synchronous to mclk but may bounce.
*/
`timescale 1ns/1ns
`include "vafp_cfg.svh"
module vafp_debounce
   import vafp_pkg::*;
#(
   parameter int DEB_CYC = `VAFP_DEB_CYC,
   parameter int TICK_CYC = `VAFP_TICK_CYC
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Raw panel inputs, keys active high.
   input wire logic [2:0] keys_raw,
   input wire logic [7:0] sw_raw,
   // Clean outputs.
   vafp_keys_if.src k
);
   logic [10:0] s1_ff;
   logic [10:0] s2_ff;
   logic [10:0] clean_ff;
   logic [19:0] deb_ff;
   logic [16:0] tick_ff;
   // A stable window of 5 ms rides out contact bounce on both keys and switches.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_ff <= 11'h000;
         s2_ff <= 11'h000;
      end
      else
      begin
         s1_ff <= {keys_raw, sw_raw};
         s2_ff <= s1_ff;
      end
   end
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         deb_ff <= 20'h00000;
         clean_ff <= 11'h000;
      end
      else if (s2_ff == clean_ff)
         deb_ff <= 20'h00000;
      else if (deb_ff == 20'(DEB_CYC))
      begin
         deb_ff <= 20'h00000;
         clean_ff <= s2_ff;
      end
      else
         deb_ff <= deb_ff + 20'h00001;
   end
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         tick_ff <= 17'h00000;
      else if (tick_ff == 17'(TICK_CYC))
         tick_ff <= 17'h00000;
      else
         tick_ff <= tick_ff + 17'h00001;
   end
   assign k.set_key = clean_ff[10];
   assign k.plus_key = clean_ff[9];
   assign k.minus_key = clean_ff[8];
   assign k.sw_tens = clean_ff[7:4];
   assign k.sw_units = clean_ff[3:0];
   assign k.tick_ms = (tick_ff == 17'(TICK_CYC));
endmodule : vafp_debounce

/* File: rtl/vafp_param_mem.sv */
/*
 Four-word store of saved operating parameters with registered read data.
 Assumes the core writes one word per cycle at most.
*/
`timescale 1ns/1ns
`include "vafp_cfg.svh"
module vafp_param_mem
   import vafp_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Access.
   input wire logic wr_en,
   input wire logic defaults,
   input wire logic [1:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [15:0] mem_ff [4];
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_ff[0] <= `VAFP_PAR_DEF0;
         mem_ff[1] <= `VAFP_PAR_DEF1;
         mem_ff[2] <= `VAFP_PAR_DEF2;
         mem_ff[3] <= `VAFP_PAR_DEF3;
      end
      else if (defaults)
      begin
         mem_ff[0] <= `VAFP_PAR_DEF0;
         mem_ff[1] <= `VAFP_PAR_DEF1;
         mem_ff[2] <= `VAFP_PAR_DEF2;
         mem_ff[3] <= `VAFP_PAR_DEF3;
      end
      else if (wr_en)
         mem_ff[addr] <= wdata;
   end
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         rdata <= 16'h0000;
      else
         rdata <= mem_ff[addr];
   end
endmodule : vafp_param_mem

/* File: rtl/vafp_panel.sv */
/*
 Front-panel controller of a proportional valve amplifier: keys, rotary switches,
 status LEDs, test-jack selection, valve type acceptance and parameter editing.
 Assumes one 100 MHz clock and operator inputs synchronous to it.
*/
// Local design decisions: the plain strobed port and the register addresses.
// How it works
// - Enable LED mirrors input, flashes standard, off expert.
// - Ready LED green ready, red error, else off.
// - Red/green on mismatch, red invalid, green flash expert.
// - Valve number is tens switch then units.
// - Jack shows switch number while it changes.
// - Decode none, types one to four, universal.
// - No valve: indicator pair rotates clockwise.
// - Mismatch keeps running on last saved type.
// - Set held over one second accepts type.
// - After accept jack returns to command value.
// - New type restores factory default parameters.
// - Editing keeps stored parameters until saved.
// - Minus press shows valve number five seconds.
// - Long set enters first parameter, simple ramp.
// - Short set opens parameter; plus/minus adjust.
// - One quadrant LED per command state.
// - Ten idle minutes abandon edit unsaved.
// - Minus with set enters expert mode.
`timescale 1ns/1ns
`include "vafp_cfg.svh"
module vafp_panel
   import vafp_pkg::*;
#(
   parameter int LONG_MS = `VAFP_LONG_MS,
   parameter int SHOW_MS = `VAFP_SHOW_MS,
   parameter int IDLE_MS = `VAFP_IDLE_MS,
   parameter int DEB_CYC = `VAFP_DEB_CYC,
   parameter int TICK_CYC = `VAFP_TICK_CYC
)
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Operator keys (set, plus, minus) and rotary switches, raw.
   input wire logic [2:0] keys_raw,
   input wire logic [7:0] sw_raw,
   // Amplifier state.
   input wire logic enable_in,
   input wire logic amp_ready,
   input wire logic amp_error,
   input wire logic cmd_positive,
   input wire logic cmd_rising,
   input wire logic [11:0] cmd_jack_mv,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   // LEDs.
   output logic enable_input_led,
   output logic ready_led_red,
   output logic ready_led_green,
   output logic [3:0] param_leds,
   output logic [3:0] quad_leds,
   // Test jack and operating parameters.
   output logic [11:0] jack_mv,
   output logic [6:0] active_valve,
   output logic [15:0] active_param,
   output logic [1:0] active_sel
);
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_VALVE = 4'h8;
   localparam logic [3:0] REG_PSEL = 4'hc;
   vafp_keys_if k ();
   vafp_state_t st_ff;
   logic expert_ff;
   logic [6:0] saved_ff;
   logic [6:0] sw_last_ff;
   logic [15:0] hold_ff;
   logic [15:0] show_ff;
   logic [19:0] idle_ff;
   logic [7:0] blink_ff;
   logic [1:0] rot_ff;
   logic [1:0] psel_ff;
   logic [15:0] edit_ff;
   logic long_done_ff;
   logic [2:0] keys_ff;
   logic [3:0] sts_ff;
   logic [3:0] mask_ff;
   logic [15:0] mem_rdata;
   logic mem_wr;
   logic [6:0] sw_num;
   logic any_key;
   logic set_rel;
   logic minus_pr;
   logic plus_pr;
   logic long_hit;
   logic mismatch;
   logic accept;
   logic idle_out;
   logic combo;

   function automatic logic valve_ok(input logic [6:0] v);
      valve_ok = (v != `VAFP_VALVE_NONE) && ((v <= `VAFP_VALVE_LAST) || (v == `VAFP_VALVE_UNIV));
   endfunction : valve_ok

   // Parameters beyond ramp, zero point and attenuator only exist on the full types.
   function automatic logic par_ok(input logic [6:0] v, input logic [1:0] p);
      par_ok = valve_ok(v) && ((p != 2'h3) || (v != 7'h01));
   endfunction : par_ok

   vafp_debounce #(.DEB_CYC(DEB_CYC), .TICK_CYC(TICK_CYC)) u_deb
   (
      .mclk(mclk),
      .arst_n(arst_n),
      .keys_raw(keys_raw),
      .sw_raw(sw_raw),
      .k(k)
   );

   vafp_param_mem u_mem
   (
      .mclk(mclk),
      .arst_n(arst_n),
      .wr_en(mem_wr),
      .defaults(accept && (sw_num != saved_ff)),
      .addr(psel_ff),
      .wdata(edit_ff),
      .rdata(mem_rdata)
   );

   assign sw_num = ({3'h0, k.sw_tens} * 7'h0a) + {3'h0, k.sw_units};
   assign any_key = k.set_key | k.plus_key | k.minus_key;
   assign set_rel = keys_ff[2] && !k.set_key;
   assign plus_pr = k.plus_key && !keys_ff[1];
   assign minus_pr = k.minus_key && !keys_ff[0] && !k.set_key;
   assign combo = k.minus_key && k.set_key && !long_done_ff;
   assign long_hit = k.set_key && !long_done_ff && (hold_ff == 16'(LONG_MS));
   assign mismatch = (sw_num != saved_ff);
   assign accept = long_hit && mismatch && valve_ok(sw_num) && (st_ff == VAFP_RUN);
   assign idle_out = (st_ff != VAFP_RUN) && (idle_ff == 20'(IDLE_MS));
   assign mem_wr = (st_ff == VAFP_EDIT) && set_rel && !long_done_ff;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         keys_ff <= 3'h0;
      else
         keys_ff <= {k.set_key, k.plus_key, k.minus_key};
   end

   // The set key's hold time is counted in 1 ms ticks.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hold_ff <= 16'h0000;
         long_done_ff <= 1'b0;
      end
      else if (!k.set_key)
      begin
         hold_ff <= 16'h0000;
         long_done_ff <= 1'b0;
      end
      else
      begin
         if (k.tick_ms && (hold_ff != 16'(LONG_MS)))
            hold_ff <= hold_ff + 16'h0001;
         if (long_hit || combo)
            long_done_ff <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         saved_ff <= `VAFP_VALVE_NONE;
      else if (accept)
         saved_ff <= sw_num;
   end

   // Menu walk: run, parameter selection, parameter open for editing.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff <= VAFP_RUN;
         expert_ff <= 1'b0;
         psel_ff <= 2'h0;
      end
      else if (idle_out)
         st_ff <= VAFP_RUN;
      else
      begin
         case (st_ff)
            VAFP_RUN:
            begin
               if (long_hit && !mismatch && valve_ok(saved_ff))
               begin
                  st_ff <= VAFP_SEL;
                  psel_ff <= 2'h0;
                  expert_ff <= 1'b0;
               end
            end
            VAFP_SEL:
            begin
               if (combo && !expert_ff)
                  expert_ff <= 1'b1;
               else if (long_hit)
                  st_ff <= VAFP_RUN;
               else if (set_rel && !long_done_ff)
                  st_ff <= VAFP_EDIT;
               else if (plus_pr && par_ok(saved_ff, psel_ff + 2'h1) && (expert_ff || psel_ff != 2'h2))
                  psel_ff <= psel_ff + 2'h1;
               else if (minus_pr && psel_ff != 2'h0)
                  psel_ff <= psel_ff - 2'h1;
            end
            VAFP_EDIT:
            begin
               if (long_hit)
                  st_ff <= VAFP_RUN;
               else if (set_rel && !long_done_ff)
                  st_ff <= VAFP_SEL;
            end
            default:
               st_ff <= VAFP_RUN;
         endcase
      end
   end

   // Edits live in a scratch copy; the store changes only when set closes the edit.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         edit_ff <= 16'h0000;
      else if (st_ff != VAFP_EDIT)
         edit_ff <= mem_rdata;
      else if (plus_pr)
         edit_ff <= edit_ff + 16'h0001;
      else if (minus_pr && edit_ff != 16'h0000)
         edit_ff <= edit_ff - 16'h0001;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         idle_ff <= 20'h00000;
      else if (any_key || st_ff == VAFP_RUN)
         idle_ff <= 20'h00000;
      else if (k.tick_ms && idle_ff != 20'(IDLE_MS))
         idle_ff <= idle_ff + 20'h00001;
   end

   // The jack shows the switch number after a switch move or a minus press in the run state.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         show_ff <= 16'h0000;
         sw_last_ff <= 7'h00;
      end
      else
      begin
         sw_last_ff <= sw_num;
         if (accept)
            show_ff <= 16'h0000;
         else if (sw_num != sw_last_ff)
            show_ff <= 16'(SHOW_MS);
         else if (minus_pr && st_ff == VAFP_RUN)
            show_ff <= 16'(SHOW_MS);
         else if (k.tick_ms && show_ff != 16'h0000 && !mismatch)
            show_ff <= show_ff - 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         jack_mv <= 12'h000;
      else if (show_ff != 16'h0000 || mismatch)
         jack_mv <= 12'(sw_num * `VAFP_JACK_STEP);
      else if (st_ff == VAFP_EDIT)
         jack_mv <= edit_ff[11:0];
      else
         jack_mv <= cmd_jack_mv;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         blink_ff <= 8'h00;
         rot_ff <= 2'h0;
      end
      else if (k.tick_ms)
      begin
         blink_ff <= (blink_ff == 8'(`VAFP_FLASH_MS)) ? 8'h00 : blink_ff + 8'h01;
         if (blink_ff == 8'(`VAFP_ROT_MS))
            rot_ff <= rot_ff + 2'h1;
      end
   end

   logic phase;
   assign phase = rot_ff[0];

   always_comb
   begin
      if (st_ff == VAFP_RUN)
         enable_input_led = enable_in;
      else
         enable_input_led = !expert_ff && phase;
   end

   always_comb
   begin
      ready_led_red = 1'b0;
      ready_led_green = 1'b0;
      if (!valve_ok(sw_num))
         ready_led_red = phase;
      else if (mismatch)
      begin
         ready_led_red = phase;
         ready_led_green = !phase;
      end
      else if (st_ff != VAFP_RUN && expert_ff)
         ready_led_green = phase;
      else if (st_ff != VAFP_RUN)
         ready_led_green = 1'b1;
      else if (amp_error)
         ready_led_red = 1'b1;
      else
         ready_led_green = amp_ready;
   end

   always_comb
   begin
      if (saved_ff == `VAFP_VALVE_NONE)
         param_leds = 4'(8'h33 >> rot_ff);
      else if (st_ff == VAFP_RUN)
         param_leds = 4'h0;
      else
         param_leds = 4'(4'h1 << psel_ff);
      quad_leds = 4'(4'h1 << {!cmd_positive, !cmd_rising});
   end

   // The amplifier always runs on the saved type and stored values.
   assign active_valve = saved_ff;
   assign active_param = mem_rdata;
   assign active_sel = psel_ff;

   // Events: accept, edit saved, edit abandoned, valve mismatch.
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         sts_ff <= 4'h0;
      else
         sts_ff <= ({idle_out, mem_wr, accept, mismatch && (sw_num != sw_last_ff)}) |
                   ((reg_rd && reg_addr == REG_STATUS) ? 4'h0 : sts_ff);
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         mask_ff <= 4'h0;
      else if (reg_wr && reg_addr == REG_MASK)
         mask_ff <= reg_wdata[3:0];
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 32'h00000000;
      else if (!reg_rd)
         reg_rdata <= 32'h00000000;
      else
      begin
         case (reg_addr)
            REG_STATUS: reg_rdata <= {28'h0000000, sts_ff};
            REG_MASK: reg_rdata <= {28'h0000000, mask_ff};
            REG_VALVE: reg_rdata <= {16'h0000, 1'b0, sw_num, 1'b0, saved_ff};
            REG_PSEL: reg_rdata <= {24'h000000, 1'b0, st_ff, expert_ff, 1'b0, psel_ff};
            default: reg_rdata <= 32'h00000000;
         endcase
      end
   end

   assign irq = |(sts_ff & mask_ff);

   a_accept_saves: assert property (@(posedge mclk) disable iff (!arst_n)
      accept |=> (saved_ff == $past(sw_num)))
      else $error("accepted valve not stored");
   a_idle_exit: assert property (@(posedge mclk) disable iff (!arst_n)
      idle_out |=> (st_ff == VAFP_RUN))
      else $error("idle edit did not return to run");
   a_run_enable: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_ff == VAFP_RUN) |-> (enable_input_led == enable_in))
      else $error("enable led not mirroring input");
   a_show_jack: assert property (@(posedge mclk) disable iff (!arst_n)
      (mismatch && $stable(sw_num)) |=> (jack_mv == 12'($past(sw_num) * `VAFP_JACK_STEP)))
      else $error("jack not showing switch number");
   a_quad_one: assert property (@(posedge mclk) disable iff (!arst_n)
      $onehot(quad_leds))
      else $error("quadrant leds not one-hot");
   a_mem_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_ff == VAFP_EDIT && !mem_wr && !accept) |=> $stable(active_param) || $changed(psel_ff))
      else $error("stored parameter moved during edit");
   a_long_enter: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_ff == VAFP_RUN && long_hit && !mismatch && valve_ok(saved_ff)) |=>
      (st_ff == VAFP_SEL && psel_ff == 2'h0))
      else $error("long set did not enter ramp");
   a_mismatch_led: assert property (@(posedge mclk) disable iff (!arst_n)
      (mismatch && valve_ok(sw_num)) |-> (ready_led_red != ready_led_green))
      else $error("mismatch led not alternating");
   a_err_red: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_ff == VAFP_RUN && !mismatch && valve_ok(sw_num) && amp_error) |-> ready_led_red)
      else $error("error not shown red");
endmodule : vafp_panel

/* File: verification/vafp_operator.sv */
/*
 Operator model: holds keys and turns the rotary switches of the panel.
 Assumes the debounce and tick counts of vafp_cfg.svh and a 100 MHz mclk.
*/
`timescale 1ns/1ns
`include "vafp_cfg.svh"
module vafp_operator
#(
   parameter int DEB = `VAFP_DEB_CYC + 1,
   parameter int MS = `VAFP_TICK_CYC + 1
)
(
   // Clock.
   input wire logic mclk,
   // Panel controls, keys {set,plus,minus}.
   output logic [2:0] keys_raw,
   output logic [7:0] sw_raw
);
   initial
   begin
      keys_raw = 3'h0;
      sw_raw = 8'h00;
   end
   // A key is held well past the debounce so the held time is what the panel times.
   task automatic press(input logic [2:0] k, input int hold_ms);
      @(posedge mclk);
      keys_raw <= k;
      repeat (DEB + hold_ms * MS) @(posedge mclk);
      keys_raw <= 3'h0;
      repeat (DEB + 2 * MS) @(posedge mclk);
      #1;
   endtask : press
   task automatic turn(input logic [3:0] tens, input logic [3:0] units);
      @(posedge mclk);
      sw_raw <= {tens, units};
      repeat (DEB + 2 * MS) @(posedge mclk);
      #1;
   endtask : turn
endmodule : vafp_operator

/* File: verification/vafp_panel_tb.sv */
/*
 Self-checking bench of the front panel with an operator model.
 Assumes vafp_cfg.svh on the include path; counts shortened by parameters.
*/
`timescale 1ns/1ns
`include "vafp_cfg.svh"
module vafp_panel_tb;
   import vafp_pkg::*;
   // Short debounce and tick keep the run small; the panel logic is the same at full counts.
   localparam int MS = 50;
   localparam int DEB = 16;
   logic mclk, arst_n, enable_in, amp_ready, amp_error, cmd_positive, cmd_rising;
   logic [11:0] cmd_jack_mv, jack_mv;
   logic [3:0] reg_addr, param_leds, quad_leds, seen_q;
   logic [31:0] reg_wdata, reg_rdata, v, r;
   logic reg_wr, reg_rd, irq, enable_input_led, ready_led_red, ready_led_green;
   logic [2:0] keys_raw;
   logic [7:0] sw_raw;
   logic [6:0] active_valve;
   logic [15:0] active_param;
   logic [1:0] active_sel;
   int n_fail, num_checks, seed, m_status;
   vafp_operator #(.DEB(DEB), .MS(MS)) u_op (.mclk(mclk), .keys_raw(keys_raw), .sw_raw(sw_raw));
   vafp_panel #(.LONG_MS(3), .SHOW_MS(5), .IDLE_MS(10), .DEB_CYC(DEB - 1), .TICK_CYC(MS - 1))
   u_vafp_panel (
      .mclk(mclk), .arst_n(arst_n), .keys_raw(keys_raw), .sw_raw(sw_raw),
      .enable_in(enable_in), .amp_ready(amp_ready), .amp_error(amp_error),
      .cmd_positive(cmd_positive), .cmd_rising(cmd_rising), .cmd_jack_mv(cmd_jack_mv),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .enable_input_led(enable_input_led),
      .ready_led_red(ready_led_red), .ready_led_green(ready_led_green),
      .param_leds(param_leds), .quad_leds(quad_leds), .jack_mv(jack_mv),
      .active_valve(active_valve), .active_param(active_param), .active_sel(active_sel));
   always #5 mclk = ~mclk;
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : chk
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_read
   // The model's status clears on read, as the sticky register does.
   task automatic status_chk();
      reg_read(4'h0, v);
      chk(v, m_status);
      m_status = 0;
   endtask : status_chk
   initial
   begin
      repeat (50000) @(posedge mclk);
      n_fail++;
      close_out();
   end
   initial
   begin
      seed = 32'h2942;
      {n_fail, num_checks, m_status} = '0;
      {mclk, arst_n, enable_in, amp_ready, amp_error, cmd_positive, cmd_rising} = '0;
      {cmd_jack_mv, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(active_valve, 0);
      chk($countones(param_leds), 2);
      status_chk();
      reg_write(4'h4, 32'hf);
      reg_read(4'h4, v);
      chk(v, 32'hf);
      reg_write(4'h2, 32'hff);
      reg_read(4'h2, v);
      chk(v, 0);
      u_op.turn(4'h1, 4'h2);
      chk(jack_mv, 12 * `VAFP_JACK_STEP);
      reg_read(4'h8, v);
      chk(v, 32'h0c00);
      u_op.turn(4'h0, 4'h3);
      m_status = 1;
      chk(jack_mv, 3 * `VAFP_JACK_STEP);
      chk(active_valve, 0);
      chk(ready_led_red != ready_led_green, 1);
      chk(irq, 1);
      status_chk();
      status_chk();
      u_op.press(3'b100, 5);
      m_status = 2;
      chk(active_valve, 3);
      status_chk();
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed);
         @(posedge mclk);
         cmd_jack_mv <= r[11:0];
         enable_in <= r[12];
         {amp_error, amp_ready} <= i[1:0];
         {cmd_positive, cmd_rising} <= i[1:0];
         repeat (3) @(posedge mclk);
         #1 chk(jack_mv, r[11:0]);
         chk(enable_input_led, r[12]);
         chk(ready_led_green, i == 1);
         chk(ready_led_red, i[1]);
         chk($onehot(quad_leds), 1);
         seen_q = (i == 0) ? quad_leds : (seen_q | quad_leds);
      end
      chk(seen_q, 4'hf);
      fork
         u_op.press(3'b001, 1);
         begin
            repeat (DEB + 2 * MS) @(posedge mclk);
            #1 chk(jack_mv, 3 * `VAFP_JACK_STEP);
         end
      join
      // The five-tick show period may still run when the key task ends.
      repeat (6 * MS) @(posedge mclk);
      #1 chk(jack_mv, cmd_jack_mv);
      u_op.press(3'b100, 5);
      reg_read(4'hc, v);
      chk(v, 32'h10);
      chk(active_sel, 0);
      u_op.press(3'b100, 1);
      reg_read(4'hc, v);
      chk(v, 32'h30);
      u_op.press(3'b010, 1);
      chk(active_param, `VAFP_PAR_DEF0);
      repeat (12 * MS) @(posedge mclk);
      reg_read(4'hc, v);
      chk(v, 0);
      m_status = 8;
      status_chk();
      chk(active_param, `VAFP_PAR_DEF0);
      u_op.press(3'b100, 5);
      u_op.press(3'b100, 1);
      u_op.press(3'b010, 1);
      u_op.press(3'b100, 1);
      m_status = 4;
      status_chk();
      chk(active_param, `VAFP_PAR_DEF0 + 16'h0001);
      u_op.press(3'b100, 5);
      reg_read(4'hc, v);
      chk(v, 0);
      u_op.turn(4'h0, 4'h4);
      u_op.press(3'b100, 5);
      m_status = 3;
      chk(active_valve, 4);
      chk(active_param, `VAFP_PAR_DEF0);
      status_chk();
      u_op.press(3'b100, 5);
      u_op.press(3'b101, 1);
      reg_read(4'hc, v);
      chk(v[3], 1);
      chk(enable_input_led, 0);
      close_out();
   end
endmodule : vafp_panel_tb
